// [i2crb_top.sv]
// i2crb_top: i2c slave serving a 32-byte ram, cpu pointers, config reg.
// assumes pins and cpu i/o strobes are synchronous to MCLK.
// Summary of operation
// (R1) address match loads bus pointer from base
// (R2) bus pointer increments per byte, saturates 31
// (R3) bus bytes use bus current pointer location
// (R4) cpu base write also loads cpu pointer
// (R5) cpu pointer wraps past last location
// (R6) buffer port reads/writes at cpu pointer, increments
// (R7) fetch-phase buffer reads are ignored
// (R8) compatible mode: port and bus pointers inert, cpu pointers still load on base writes
// (R9) pin select fixed while enabled
// (R10) stop interrupt only on flag rise
// (R11) rate field selects bus speed
// (R12) standard rates prescale /8 /4 /16
// (R13) fast rate prescale /2 /1 /4
// (R14) disabled: status cleared, logic reset, pins released
// (R15) disabled: cpu buffer access blocked
// (R16) enable synchronised before use
// (R17) interrupt on start plus address
// (R18) start restarts address, stop idles
// (R19) bit timing follows external master
// (R20) software forces nack before disabling; there is no nack control, every matched address and write byte is acked
// (R21) first write byte sets bus base
// (R22) acts as auto-acking ram, never stalls
// (R23) saturated pointer keeps last location
`timescale 1ns/1ps
module i2crb_top
    import i2crb_pkg::*;
#(
    parameter int DW = 8,
    parameter int AW = 5
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic IO_EXECUTE_PHASE,
    output logic [7:0] IO_RDATA,
    input wire logic BUF_MODE,
    input wire logic [1:0] OSC_SPEED,
    input wire logic [6:0] SLAVE_ADDR,
    input wire logic STOP_CLR,
    input wire logic SCL0_I,
    input wire logic SDA0_I,
    input wire logic SCL1_I,
    input wire logic SDA1_I,
    output logic SDA0_O,
    output logic SDA0_OE_N,
    output logic SDA1_O,
    output logic SDA1_OE_N,
    output logic [1:0] PIN_OWN,
    output logic STOP_FLAG,
    output logic IRQ
);
    localparam int FW = AW + DW;

    // prescale factor from rate and oscillator speed
    function automatic logic [4:0] prescale(input logic [1:0] rate, input logic [1:0] osc);
        logic [4:0] p;
        p = PRE_RSV;
        case (rate) // R11
            RATE_100K, RATE_50K: begin // R12
                case (osc)
                    OSC_S0: p = PRE_STD_S0;
                    OSC_S1: p = PRE_STD_S1;
                    OSC_S2: p = PRE_STD_S2;
                    default: p = PRE_RSV;
                endcase
            end
            RATE_400K: begin // R13
                case (osc)
                    OSC_S0: p = PRE_FST_S0;
                    OSC_S1: p = PRE_FST_S1;
                    OSC_S2: p = PRE_FST_S2;
                    default: p = PRE_RSV;
                endcase
            end
            default: p = PRE_RSV;
        endcase
        return p;
    endfunction

    function automatic logic [4:0] ptr_sat(input logic [4:0] p);
        return (p == PTR_LAST) ? p : 5'(p + PTR_STEP);
    endfunction

    logic [7:0] cfg_r;
    logic en_s1_r, en_s2_r, en;
    logic [4:0] pre_cnt_r;
    logic tick_r, smp_r;
    logic scl_r, scl_p_r, sda_r, sda_p_r;
    logic scl_rise, scl_fall, start_c, stop_c;
    i2crb_st_t st_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_r;
    logic got8_r, rw_r, first_r, nack_r, busy_r, sda_low_r;
    logic addr_evt_r, stop_evt_r;
    logic [4:0] bp_bus_r, cp_bus_r, bp_cpu_r, cp_cpu_r;
    logic push_pend_r;
    logic [FW-1:0] push_data_r;
    logic [7:0] mem_r [0:31];
    logic [FW-1:0] fq_r [0:1];
    logic [1:0] fcnt_r;
    logic fhead_r;
    logic fin_rdy, fout_vld, fout_rdy, fpush, fpop;
    logic [FW-1:0] fout;
    logic buf_ok, cpu_wr_buf, cpu_rd_buf, scl_in, sda_in;

    assign en = en_s2_r;
    assign buf_ok = en && BUF_MODE; // R8 R15
    assign cpu_wr_buf = IO_WR && IO_ADDR == ADR_BUF && buf_ok;
    assign cpu_rd_buf = IO_RD && IO_EXECUTE_PHASE && IO_ADDR == ADR_BUF && buf_ok; // R7
    assign scl_in = cfg_r[CFG_PSEL] ? SCL1_I : SCL0_I; // R9
    assign sda_in = cfg_r[CFG_PSEL] ? SDA1_I : SDA0_I;

    // configuration register, kept through disable
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            cfg_r <= CFG_RST;
        end else if (IO_WR && IO_ADDR == ADR_CFG) begin
            cfg_r <= IO_WDATA & CFG_WMASK;
            if (cfg_r[CFG_EN]) begin
                cfg_r[CFG_PSEL] <= cfg_r[CFG_PSEL]; // R9
            end
        end
    end

    // enable synchroniser
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end else begin
            en_s1_r <= cfg_r[CFG_EN]; // R16
            en_s2_r <= en_s1_r;
        end
    end

    // sample-rate divider
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !en) begin
            pre_cnt_r <= PTR_RST;
            tick_r <= 1'b0;
        end else if (5'(pre_cnt_r + PTR_STEP) >= prescale(cfg_r[CFG_RATE_LO+:2], OSC_SPEED)) begin
            pre_cnt_r <= PTR_RST; // R12 R13
            tick_r <= 1'b1;
        end else begin
            pre_cnt_r <= 5'(pre_cnt_r + PTR_STEP);
            tick_r <= 1'b0;
        end
    end

    // bus line sampling
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !en) begin
            scl_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_r <= 1'b1;
            sda_p_r <= 1'b1;
            smp_r <= 1'b0;
        end else begin
            smp_r <= tick_r;
            if (tick_r) begin
                scl_r <= scl_in;
                scl_p_r <= scl_r;
                sda_r <= sda_in;
                sda_p_r <= sda_r;
            end
        end
    end

    assign scl_rise = smp_r && scl_r && !scl_p_r; // R19
    assign scl_fall = smp_r && !scl_r && scl_p_r;
    assign start_c = smp_r && scl_r && scl_p_r && sda_p_r && !sda_r;
    assign stop_c = smp_r && scl_r && scl_p_r && !sda_p_r && sda_r;

    // slave protocol engine and bus-side pointers
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !en) begin // R14
            st_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            sh_r <= RD_RST;
            got8_r <= 1'b0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            busy_r <= 1'b0;
            sda_low_r <= 1'b0;
            addr_evt_r <= 1'b0;
            stop_evt_r <= 1'b0;
            bp_bus_r <= PTR_RST;
            cp_bus_r <= PTR_RST;
            push_pend_r <= 1'b0;
            push_data_r <= '0;
        end else begin
            addr_evt_r <= 1'b0;
            stop_evt_r <= 1'b0;
            if (fpush) begin
                push_pend_r <= 1'b0;
            end
            if (start_c) begin // R18
                st_r <= ST_ADDR;
                bit_cnt_r <= 3'h0;
                got8_r <= 1'b0;
                sda_low_r <= 1'b0;
                busy_r <= 1'b0;
            end else if (stop_c) begin // R18
                st_r <= ST_IDLE;
                sda_low_r <= 1'b0;
                stop_evt_r <= busy_r;
                busy_r <= 1'b0;
            end else if (scl_rise) begin
                if (st_r == ST_TACK) begin
                    nack_r <= sda_r;
                    cp_bus_r <= ptr_sat(cp_bus_r); // R2 R23
                end else if (st_r == ST_ADDR || st_r == ST_RX || st_r == ST_TX) begin
                    sh_r <= {sh_r[6:0], sda_r};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    got8_r <= bit_cnt_r == LAST_BIT;
                end
            end else if (scl_fall) begin
                case (st_r)
                    ST_ADDR: begin
                        if (got8_r && sh_r[7:1] == SLAVE_ADDR && BUF_MODE) begin // R8
                            st_r <= ST_AACK;
                            sda_low_r <= 1'b1; // R22
                            rw_r <= sh_r[0];
                            first_r <= !sh_r[0];
                            busy_r <= 1'b1;
                            addr_evt_r <= 1'b1; // R17
                            cp_bus_r <= bp_bus_r; // R1
                        end else if (got8_r) begin
                            st_r <= ST_IDLE;
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        got8_r <= 1'b0;
                        bit_cnt_r <= 3'h0;
                        if (rw_r) begin
                            st_r <= ST_TX;
                            sh_r <= mem_r[cp_bus_r]; // R3
                            sda_low_r <= !mem_r[cp_bus_r][7];
                        end else begin
                            st_r <= ST_RX;
                            sda_low_r <= 1'b0;
                        end
                    end
                    ST_RX: begin
                        if (got8_r) begin
                            st_r <= ST_RACK;
                            sda_low_r <= 1'b1; // R22
                            first_r <= 1'b0;
                            if (first_r) begin // R21
                                bp_bus_r <= sh_r[4:0];
                                cp_bus_r <= sh_r[4:0];
                            end else begin
                                push_pend_r <= 1'b1;
                                push_data_r <= {cp_bus_r, sh_r}; // R3
                                cp_bus_r <= ptr_sat(cp_bus_r); // R2 R23
                            end
                        end
                    end
                    ST_TX: begin
                        if (got8_r) begin
                            st_r <= ST_TACK;
                            sda_low_r <= 1'b0;
                        end else begin
                            sda_low_r <= !sh_r[7];
                        end
                    end
                    ST_TACK: begin
                        got8_r <= 1'b0;
                        bit_cnt_r <= 3'h0;
                        if (nack_r) begin
                            st_r <= ST_IDLE;
                        end else begin
                            st_r <= ST_TX;
                            sh_r <= mem_r[cp_bus_r]; // R3
                            sda_low_r <= !mem_r[cp_bus_r][7];
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // two-entry receive buffer between shifter and ram
    assign fin_rdy = fcnt_r != 2'h2;
    assign fout_vld = fcnt_r != 2'h0;
    assign fout_rdy = !cpu_wr_buf;
    assign fpush = push_pend_r && fin_rdy;
    assign fpop = fout_vld && fout_rdy;
    assign fout = fq_r[fhead_r];

    always_ff @(posedge MCLK) begin
        if (!RESET_N || !en) begin
            fcnt_r <= 2'h0;
            fhead_r <= 1'b0;
        end else begin
            fcnt_r <= 2'(fcnt_r + {1'b0, fpush} - {1'b0, fpop});
            fhead_r <= fhead_r ^ fpop;
        end
    end

    always_ff @(posedge MCLK) begin
        if (fpush) begin
            fq_r[fhead_r ^ fcnt_r[0]] <= push_data_r;
        end
    end

    // shared ram, cpu port wins and stalls the buffer
    always_ff @(posedge MCLK) begin
        if (cpu_wr_buf) begin
            mem_r[cp_cpu_r] <= IO_WDATA; // R6
        end else if (fpop) begin
            mem_r[fout[FW-1:DW]] <= fout[DW-1:0]; // R3
        end
    end

    // cpu-side pointers
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !en) begin // R14
            bp_cpu_r <= PTR_RST;
            cp_cpu_r <= PTR_RST;
        end else if (IO_WR && IO_ADDR == ADR_CPU_SIDE_BASE_POINTER) begin
            bp_cpu_r <= IO_WDATA[4:0]; // R4
            cp_cpu_r <= IO_WDATA[4:0];
        end else if (cpu_wr_buf || cpu_rd_buf) begin
            cp_cpu_r <= 5'(cp_cpu_r + PTR_STEP); // R5 R6
        end
    end

    // cpu read data
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            IO_RDATA <= RD_RST;
        end else if (IO_RD) begin
            case (IO_ADDR)
                ADR_BUS_CP: IO_RDATA <= {3'h0, cp_bus_r};
                ADR_CPU_SIDE_BASE_POINTER: IO_RDATA <= {3'h0, bp_cpu_r};
                ADR_CPU_SIDE_CURRENT_POINTER: IO_RDATA <= {3'h0, cp_cpu_r};
                ADR_BUF: IO_RDATA <= buf_ok ? mem_r[cp_cpu_r] : RD_RST; // R6 R15
                ADR_CFG: IO_RDATA <= cfg_r;
                default: IO_RDATA <= RD_RST;
            endcase
        end
    end

    // stop flag and interrupt
    always_ff @(posedge MCLK) begin
        if (!RESET_N || !en) begin // R14
            STOP_FLAG <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            STOP_FLAG <= stop_evt_r || (STOP_FLAG && !STOP_CLR);
            IRQ <= addr_evt_r || (stop_evt_r && !STOP_FLAG && cfg_r[CFG_STOP_INTERRUPT_ENABLE]); // R10 R17
        end
    end

    // pin drivers, released while disabled
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            SDA0_O <= 1'b0;
            SDA1_O <= 1'b0;
            SDA0_OE_N <= 1'b1;
            SDA1_OE_N <= 1'b1;
            PIN_OWN <= 2'h0;
        end else begin
            SDA0_O <= 1'b0;
            SDA1_O <= 1'b0;
            SDA0_OE_N <= !(en && sda_low_r && !cfg_r[CFG_PSEL]); // R14
            SDA1_OE_N <= !(en && sda_low_r && cfg_r[CFG_PSEL]);
            PIN_OWN <= en ? (cfg_r[CFG_PSEL] ? 2'h2 : 2'h1) : 2'h0; // R9 R14
        end
    end
endmodule

// [i2crb_pkg.sv]
// i2crb_pkg: register offsets, config fields, timing and state codes
// for the buffered i2c slave; assumes an 8-bit cpu i/o register space.
package i2crb_pkg;
    // register offsets in the cpu i/o space
    localparam logic [7:0] ADR_BUS_CP = 8'hcc;
    localparam logic [7:0] ADR_CPU_SIDE_BASE_POINTER = 8'hcd;
    localparam logic [7:0] ADR_CPU_SIDE_CURRENT_POINTER = 8'hce;
    localparam logic [7:0] ADR_BUF = 8'hcf;
    localparam logic [7:0] ADR_CFG = 8'hd6;
    // configuration fields
    localparam int CFG_EN = 0;
    localparam int CFG_RATE_LO = 2;
    localparam int CFG_STOP_INTERRUPT_ENABLE = 4;
    localparam int CFG_PSEL = 6;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'h7d;
    localparam logic [7:0] RD_RST = 8'h00;
    // buffer pointers
    localparam logic [4:0] PTR_RST = 5'h00;
    localparam logic [4:0] PTR_LAST = 5'h1f;
    localparam logic [4:0] PTR_STEP = 5'h01;
    // clock rate codes
    localparam logic [1:0] RATE_100K = 2'h0;
    localparam logic [1:0] RATE_400K = 2'h1;
    localparam logic [1:0] RATE_50K = 2'h2;
    // oscillator speed codes
    localparam logic [1:0] OSC_S0 = 2'h0;
    localparam logic [1:0] OSC_S1 = 2'h1;
    localparam logic [1:0] OSC_S2 = 2'h2;
    // prescale factors
    localparam logic [4:0] PRE_STD_S0 = 5'h08;
    localparam logic [4:0] PRE_STD_S1 = 5'h04;
    localparam logic [4:0] PRE_STD_S2 = 5'h10;
    localparam logic [4:0] PRE_FST_S0 = 5'h02;
    localparam logic [4:0] PRE_FST_S1 = 5'h01;
    localparam logic [4:0] PRE_FST_S2 = 5'h04;
    localparam logic [4:0] PRE_RSV = 5'h01;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RX = 3'b011,
        ST_RACK = 3'b100,
        ST_TX = 3'b101,
        ST_TACK = 3'b110
    } i2crb_st_t;
endpackage

// [i2crb_top_sva.sv]
// i2crb_top_sva: port checks for the buffered i2c slave
// bound into i2crb_top; sees its ports only
`timescale 1ns/1ps
module i2crb_top_sva
    import i2crb_pkg::*;
#(
    parameter int DW = 8,
    parameter int AW = 5
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_RDATA,
    input wire logic BUF_MODE,
    input wire logic SDA0_OE_N,
    input wire logic SDA1_OE_N,
    input wire logic [1:0] PIN_OWN,
    input wire logic STOP_FLAG,
    input wire logic IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    logic own_r;
    logic dis;
    always_ff @(posedge MCLK) begin
        own_r <= (PIN_OWN != 2'h0);
    end
    // disabled and settled for two cycles
    assign dis = (PIN_OWN == 2'h0) && !own_r;
    property p_pair_fixed;
        (PIN_OWN != 2'h0) && own_r |-> PIN_OWN == $past(PIN_OWN);
    endproperty
    a_pair_fixed: assert property (p_pair_fixed) else $error("pin pair moved");
    property p_alt_only;
        PIN_OWN == 2'h2 |-> SDA0_OE_N;
    endproperty
    a_alt_only: assert property (p_alt_only) else $error("primary pair driven");
    property p_released;
        dis |-> SDA0_OE_N && SDA1_OE_N;
    endproperty
    a_released: assert property (p_released) else $error("pins held when off");
    property p_status_clr;
        dis |-> !STOP_FLAG && !IRQ;
    endproperty
    a_status_clr: assert property (p_status_clr) else $error("status kept when off");
    property p_en_sync;
        IO_WR && IO_ADDR == ADR_CFG && IO_WDATA[CFG_EN] && dis
            |=> PIN_OWN == 2'h0 ##[1:4] PIN_OWN != 2'h0;
    endproperty
    a_en_sync: assert property (p_en_sync) else $error("enable timing wrong");
    property p_buf_blocked;
        IO_RD && IO_ADDR == ADR_BUF && dis |=> IO_RDATA == 8'h00;
    endproperty
    a_buf_blocked: assert property (p_buf_blocked) else $error("buffer read when off");
    property p_compat_inert;
        IO_RD && IO_ADDR == ADR_BUF && !BUF_MODE |=> IO_RDATA == 8'h00;
    endproperty
    a_compat_inert: assert property (p_compat_inert) else $error("port live in compat");
    property p_bus_ptr;
        IO_RD && IO_ADDR == ADR_BUS_CP && dis |=> IO_RDATA == 8'h00;
    endproperty
    a_bus_ptr: assert property (p_bus_ptr) else $error("bus pointer kept when off");
    c_irq: cover property (IRQ);
    c_stop: cover property ($rose(STOP_FLAG));
    c_alt: cover property (PIN_OWN == 2'h2);
endmodule
bind i2crb_top i2crb_top_sva #(.DW(DW), .AW(AW)) i_i2crb_top_sva (
    .MCLK(MCLK), .RESET_N(RESET_N), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
    .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA), .BUF_MODE(BUF_MODE),
    .SDA0_OE_N(SDA0_OE_N), .SDA1_OE_N(SDA1_OE_N), .PIN_OWN(PIN_OWN),
    .STOP_FLAG(STOP_FLAG), .IRQ(IRQ)
);

// [i2crb_master.sv]
// i2crb_master: behavioural i2c bus master on one scl/sda pair
// assumes open-drain wiring with pull-ups made by the bench
`timescale 1ns/1ps
module i2crb_master #(
    parameter int HALF = 1520
) (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // start or repeated start
    task automatic start();
        #(HALF / 2) sda_m = 1'b1;
        #(HALF) scl = 1'b1;
        #(HALF) sda_m = 1'b0;
        #(HALF) scl = 1'b0;
    endtask
    task automatic stop();
        #(HALF / 2) sda_m = 1'b0;
        #(HALF) scl = 1'b1;
        #(HALF) sda_m = 1'b1;
        #(HALF);
    endtask
    // msb first, ninth bit sampled; d=ff releases the line to read
    task automatic xfer(input logic [7:0] d, input logic a,
        output logic [7:0] q, output logic ack);
        logic [8:0] v;
        logic [8:0] r;
        v = {d, a};
        for (int i = 8; i >= 0; i--) begin
            #(HALF / 2) sda_m = v[i];
            #(HALF) scl = 1'b1;
            #(HALF) r[i] = sda;
            scl = 1'b0;
        end
        q = r[8:1];
        ack = r[0];
    endtask
endmodule

// [i2crb_top_tb.sv]
// i2crb_top_tb: self-checking bench for the buffered i2c slave
// assumes i2crb_master as bus master, pull-ups on both pairs
`timescale 1ns/1ps
module i2crb_top_tb
    import i2crb_pkg::*;
;
    logic mclk, reset_n, io_wr, io_rd, io_execute_phase, buf_mode, stop_clr, alt, scl, sda_m, ak;
    logic sda0_o, sda0_oe_n, sda1_o, sda1_oe_n, stop_flag, irq;
    logic [7:0] io_addr, io_wdata, io_rdata, q, d, cfg;
    logic [1:0] osc_speed, pin_own;
    logic [6:0] saddr;
    logic [7:0] mem [32];
    logic [7:0] regs [6] = '{ADR_BUS_CP, ADR_CPU_SIDE_BASE_POINTER, ADR_CPU_SIDE_CURRENT_POINTER, ADR_BUF, ADR_CFG, 8'h00};
    int n_mismatch = 0, tests_run = 0, irq_n = 0, e_irq = 0, bcur, ccur, off, ob;
    integer seed = 36;
    wire sda0 = (alt | sda_m) & (sda0_oe_n | sda0_o);
    wire sda1 = (!alt | sda_m) & (sda1_oe_n | sda1_o);
    wire sda = alt ? sda1 : sda0;
    i2crb_top i_i2crb_top (
        .MCLK(mclk), .RESET_N(reset_n), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
        .IO_WR(io_wr), .IO_RD(io_rd), .IO_EXECUTE_PHASE(io_execute_phase), .IO_RDATA(io_rdata),
        .BUF_MODE(buf_mode), .OSC_SPEED(osc_speed), .SLAVE_ADDR(saddr),
        .STOP_CLR(stop_clr), .SCL0_I(alt | scl), .SDA0_I(sda0), .SCL1_I(!alt | scl),
        .SDA1_I(sda1), .SDA0_O(sda0_o), .SDA0_OE_N(sda0_oe_n), .SDA1_O(sda1_o),
        .SDA1_OE_N(sda1_oe_n), .PIN_OWN(pin_own), .STOP_FLAG(stop_flag), .IRQ(irq)
    );
    i2crb_master #(.HALF(1520)) i_i2crb_master (.scl(scl), .sda_m(sda_m), .sda(sda));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (irq === 1'b1) irq_n++;
    function automatic logic [7:0] rnd();
        int r;
        r = $random(seed);
        return r[7:0];
    endfunction
    function automatic int sat(input int p);
        return (p < 31) ? p + 1 : 31;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1 {io_addr, io_wdata, io_wr} = {a, v, 1'b1};
        @(posedge mclk);
        #1 io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic ex, output logic [7:0] v);
        @(posedge mclk);
        #1 {io_addr, io_execute_phase, io_rd} = {a, ex, 1'b1};
        @(posedge mclk);
        #1 io_rd = 1'b0;
        v = io_rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a, 1'b1, q);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic bx(input logic [7:0] v, input logic ea);
        i_i2crb_master.xfer(v, 1'b1, q, ak);
        chk("ack", {7'h0, ea}, {7'h0, ak});
    endtask
    task automatic cread(input int b);
        wr(ADR_CPU_SIDE_BASE_POINTER, b[7:0]);
        ccur = b;
        rc(ADR_CPU_SIDE_CURRENT_POINTER, ccur[7:0]);
        for (int i = 0; i < 4; i++) begin
            rc(ADR_BUF, mem[ccur]);
            ccur = (ccur + 1) % 32;
        end
        rc(ADR_CPU_SIDE_CURRENT_POINTER, ccur[7:0]);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #1_950_000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {reset_n, io_wr, io_rd, io_execute_phase, stop_clr, alt} = 6'h00;
        {io_addr, io_wdata, osc_speed, buf_mode} = {8'h00, 8'h00, 2'h0, 1'b1};
        d = rnd();
        saddr = d[6:0];
        repeat (10) @(posedge mclk);
        #1 reset_n = 1'b1;
        foreach (regs[i]) rc(regs[i], 8'h00);
        wr(ADR_BUF, 8'h5a);
        wr(ADR_CPU_SIDE_BASE_POINTER, 8'h07);
        rc(ADR_CPU_SIDE_CURRENT_POINTER, 8'h00);
        for (int k = 0; k < 3; k++) begin
            alt = k[0];
            osc_speed = k[1:0];
            cfg = {1'b0, alt, 2'b01, k[1:0], 2'b01};
            wr(ADR_CFG, cfg);
            repeat (6) @(posedge mclk);
            chk("pins", {6'h0, alt, !alt}, {6'h0, pin_own});
            wr(ADR_CFG, cfg ^ 8'h40);
            rc(ADR_CFG, cfg);
            d = rnd();
            ccur = (k == 2) ? 30 : d[4:0];
            wr(ADR_CPU_SIDE_BASE_POINTER, ccur[7:0]);
            off = ccur;
            for (int i = 0; i < ((k == 0) ? 33 : 4); i++) begin
                d = rnd();
                wr(ADR_BUF, d);
                mem[ccur] = d;
                ccur = (ccur + 1) % 32;
            end
            rd(ADR_BUF, 1'b0, q);
            rc(ADR_CPU_SIDE_CURRENT_POINTER, ccur[7:0]);
            cread(off);
            d = rnd();
            off = (k == 1) ? 29 : d[4:0];
            bcur = off;
            i_i2crb_master.start();
            bx({saddr, 1'b0}, 1'b0);
            bx(off[7:0], 1'b0);
            for (int i = 0; i < 4; i++) begin
                d = rnd();
                bx(d, 1'b0);
                mem[bcur] = d;
                bcur = sat(bcur);
            end
            i_i2crb_master.start();
            bx({saddr, 1'b1}, 1'b0);
            bcur = off;
            for (int i = 0; i < 3; i++) begin
                i_i2crb_master.xfer(8'hff, i == 2, q, ak);
                chk("rdata", mem[bcur], q);
                bcur = sat(bcur);
            end
            i_i2crb_master.stop();
            e_irq += 3;
            chk("stop", 8'h01, {7'h0, stop_flag});
            chk("irq", e_irq[7:0], irq_n[7:0]);
            rc(ADR_BUS_CP, bcur[7:0]);
            d = rnd();
            ob = d[4:0];
            i_i2crb_master.start();
            bx({saddr, 1'b0}, 1'b0);
            bx(ob[7:0], 1'b0);
            i_i2crb_master.stop();
            e_irq += 1;
            chk("irq", e_irq[7:0], irq_n[7:0]);
            rc(ADR_BUS_CP, ob[7:0]);
            if (k < 2) begin
                @(posedge mclk);
                #1 stop_clr = 1'b1;
                @(posedge mclk);
                #1 stop_clr = 1'b0;
            end
            i_i2crb_master.start();
            bx({~saddr, 1'b0}, 1'b1);
            i_i2crb_master.stop();
            chk("stop", {7'h0, k == 2}, {7'h0, stop_flag});
            chk("irq", e_irq[7:0], irq_n[7:0]);
            cread(off);
            wr(ADR_CFG, 8'h00);
            repeat (4) @(posedge mclk);
            chk("off", 8'h00, {5'h0, stop_flag, pin_own});
            rc(ADR_CPU_SIDE_CURRENT_POINTER, 8'h00);
        end
        wr(ADR_CFG, 8'h11);
        buf_mode = 1'b0;
        rc(ADR_BUF, 8'h00);
        i_i2crb_master.start();
        bx({saddr, 1'b0}, 1'b1);
        i_i2crb_master.stop();
        wrap_up();
    end
endmodule
